/* File: inc/term_pd_pkg.sv */
// constants, command codes and carriers for the termination and power-down control
package term_pd_pkg;

	// core clock period in ns
	localparam int CORE_CLK_PERIOD_NS = 10;

	// mode register addresses and fields
	localparam logic [7:0] MA_TERMINATION  = 8'h0B;
	localparam logic [7:0] MA_WRITE_LEVEL  = 8'h02;
	localparam logic [7:0] MA_CA_TRAIN_ON  = 8'h29;
	localparam logic [7:0] MA_CA_TRAIN_OFF = 8'h2A;
	localparam int RTT_SELECT_LSB         = 0;
	localparam int TERM_IN_PD_POS         = 2;
	localparam int WRITE_LEVEL_POS        = 7;
	localparam logic [7:0] TERMINATION_MODE_RESET = 8'h00;
	localparam logic [1:0] RTT_OFF        = 2'h0;

	// link-side cycle counts (the first eight are defaults of module parameters)
	localparam int READ_LATENCY_DEFAULT   = 12;
	localparam int WRITE_LATENCY_DEFAULT  = 6;
	localparam int BURST_LENGTH_DEFAULT   = 8;
	localparam int SKEW_CYCLES_DEFAULT    = 3;
	localparam int WR_RECOVERY_DEFAULT    = 8;
	localparam int CKE_MIN_PULSE_DEFAULT  = 3;
	localparam int EXIT_LATENCY_DEFAULT   = 3;
	localparam int ZQ_CAL_CYCLES_DEFAULT  = 64;
	localparam int CKE_INTERNAL_DELAY_CYCLES = 2;
	localparam int READ_OFF_LEAD_CYCLES   = 2;

	// core-side termination windows, longest times round down
	localparam int TERM_DISABLE_WINDOW_NS = 20;
	localparam int TERM_ENABLE_WINDOW_NS  = 20;
	localparam int TERM_DISABLE_CYCLES    = (TERM_DISABLE_WINDOW_NS / CORE_CLK_PERIOD_NS) < 1 ? 1
		: TERM_DISABLE_WINDOW_NS / CORE_CLK_PERIOD_NS;
	localparam int TERM_ENABLE_CYCLES     = (TERM_ENABLE_WINDOW_NS / CORE_CLK_PERIOD_NS) < 1 ? 1
		: TERM_ENABLE_WINDOW_NS / CORE_CLK_PERIOD_NS;

	// decoded command on the link
	typedef enum logic [3:0] {
		CMD_NOP       = 4'h0,
		CMD_READ      = 4'h1,
		CMD_READ_AP   = 4'h2,
		CMD_WRITE     = 4'h3,
		CMD_WRITE_AP  = 4'h4,
		CMD_MRR       = 4'h5,
		CMD_MRW       = 4'h6,
		CMD_ACTIVATE  = 4'h7,
		CMD_PRECHARGE = 4'h8,
		CMD_REFRESH   = 4'h9,
		CMD_SREF      = 4'hA,
		CMD_DPD       = 4'hB,
		CMD_ZQ_CAL    = 4'hC
	} cmd_e;

	typedef struct packed {
		logic       cke;
		logic       cs_n;
		cmd_e       op;
		logic [7:0] ma;
		logic [7:0] op_data;
	} link_cmd_s;

	typedef struct packed {
		logic dq_term_en;
		logic dqs_term_en;
	} term_out_s;

	// power-down states
	typedef enum logic [5:0] {
		ST_ACTIVE    = 6'h01,
		ST_PD_WAIT   = 6'h02,
		ST_POWERDOWN = 6'h04,
		ST_PD_EXIT   = 6'h08,
		ST_SELFREF   = 6'h10,
		ST_DEEP_PD   = 6'h20
	} pd_state_e;

endpackage

/* File: verilog/term_pd_ctrl.sv */
// termination switch control and clock-enable power-down state of the memory die
`timescale 1ns/1ps
module term_pd_ctrl
	import term_pd_pkg::*;
#(
	parameter int READ_LATENCY  = READ_LATENCY_DEFAULT,
	parameter int WRITE_LATENCY = WRITE_LATENCY_DEFAULT,
	parameter int BURST_LENGTH  = BURST_LENGTH_DEFAULT,
	parameter int SKEW_CYCLES   = SKEW_CYCLES_DEFAULT,
	parameter int WR_RECOVERY   = WR_RECOVERY_DEFAULT,
	parameter int CKE_MIN_PULSE = CKE_MIN_PULSE_DEFAULT,
	parameter int EXIT_LATENCY  = EXIT_LATENCY_DEFAULT,
	parameter int ZQ_CAL_CYCLES = ZQ_CAL_CYCLES_DEFAULT
) (
	// core domain
	input  wire logic      core_clk,
	input  wire logic      reset,
	input  wire logic      enable,
	// link domain
	input  wire logic      mem_clk,
	input  wire logic      link_reset,
	input  wire link_cmd_s link_cmd,
	// termination pin, unclocked
	input  wire logic      on_die_termination_pin,
	// termination switches
	output term_out_s      term_out,
	output logic [1:0]     termination_resistance,
	// state and checks
	output logic           receivers_on,
	output pd_state_e      pd_state,
	output logic           protocol_violation
);

	localparam int CW = 8;
	localparam int READ_END      = READ_LATENCY + BURST_LENGTH / 2;
	localparam int READ_CKE_GAP  = READ_LATENCY + SKEW_CYCLES + BURST_LENGTH / 2 + 1;
	localparam int WRITE_CKE_GAP = WRITE_LATENCY + 1 + BURST_LENGTH / 2 + WR_RECOVERY;
	localparam logic [7:0] STATUS_RESET = {RTT_OFF, ST_ACTIVE};

	function automatic logic [CW-1:0] count_of(input int value);
		count_of = CW'(value);
	endfunction

	function automatic logic [CW-1:0] max_gap(input logic [CW-1:0] a, input logic [CW-1:0] b);
		max_gap = (a > b) ? a : b;
	endfunction

	// ---------------- link domain ----------------
	logic [7:0]      termination_mode_reg;
	logic            write_level;
	logic            ca_train;
	logic            cke_q;
	pd_state_e       state;
	pd_state_e       next_state;
	logic [CW-1:0]   state_cnt;
	logic [CW-1:0]   next_state_cnt;
	logic [CW-1:0]   rd_cnt;
	logic [CW-1:0]   next_rd_cnt;
	logic            read_off;
	logic [CW-1:0]   zq_cnt;
	logic [CW-1:0]   cke_block_cnt;
	logic [CW-1:0]   next_cke_block_cnt;
	logic [CW-1:0]   cke_level_cnt;
	logic            link_violation;
	logic            lp_gate;
	logic [7:0]      link_status;

	wire logic [1:0] rtt_select_field     = termination_mode_reg[RTT_SELECT_LSB +: 2];
	wire logic       term_in_powerdown_bit = termination_mode_reg[TERM_IN_PD_POS];
	wire logic       cmd_valid            = link_cmd.cke && cke_q && !link_cmd.cs_n;
	wire logic       is_mrw               = cmd_valid && link_cmd.op == CMD_MRW;
	wire logic       is_read              = cmd_valid && (link_cmd.op == CMD_READ ||
		link_cmd.op == CMD_READ_AP || link_cmd.op == CMD_MRR);
	wire logic       is_write             = cmd_valid && link_cmd.op == CMD_WRITE;
	wire logic       is_write_ap          = cmd_valid && link_cmd.op == CMD_WRITE_AP;
	wire logic       cke_fall             = cke_q && !link_cmd.cke;
	wire logic       cke_rise             = !cke_q && link_cmd.cke;
	wire logic [1:0] next_rtt             = (is_mrw && link_cmd.ma == MA_TERMINATION)
		? link_cmd.op_data[RTT_SELECT_LSB +: 2] : rtt_select_field;

	// mode register writes
	always_ff @(posedge mem_clk) begin
		if (link_reset) begin
			termination_mode_reg <= TERMINATION_MODE_RESET;
			write_level          <= 1'b0;
			ca_train             <= 1'b0;
		end else if (is_mrw) begin
			if (link_cmd.ma == MA_TERMINATION)
				termination_mode_reg <= link_cmd.op_data;
			if (link_cmd.ma == MA_WRITE_LEVEL)
				write_level <= link_cmd.op_data[WRITE_LEVEL_POS];
			if (link_cmd.ma == MA_CA_TRAIN_ON)
				ca_train <= 1'b1;
			if (link_cmd.ma == MA_CA_TRAIN_OFF)
				ca_train <= 1'b0;
		end
	end

	// power-down state machine
	always_comb begin
		next_state     = state;
		next_state_cnt = (state_cnt != '0) ? state_cnt - 1'b1 : state_cnt;
		case (state)
			ST_ACTIVE: begin
				if (cke_fall && link_cmd.cs_n) begin
					next_state     = ST_PD_WAIT;
					next_state_cnt = count_of(CKE_INTERNAL_DELAY_CYCLES - 1);
				end else if (cke_fall && link_cmd.op == CMD_SREF) begin
					next_state = ST_SELFREF;
				end else if (cke_fall && link_cmd.op == CMD_DPD) begin
					next_state = ST_DEEP_PD;
				end
			end
			ST_PD_WAIT: begin
				// receivers stay on until delay expires
				if (state_cnt == '0)
					next_state = ST_POWERDOWN;
			end
			ST_POWERDOWN, ST_SELFREF: begin
				if (link_cmd.cke) begin
					next_state     = ST_PD_EXIT;
					next_state_cnt = count_of(EXIT_LATENCY - 1);
				end
			end
			ST_PD_EXIT: begin
				if (state_cnt == '0)
					next_state = ST_ACTIVE;
			end
			ST_DEEP_PD: begin
				// off for the whole deep power down
				if (link_cmd.cke)
					next_state = ST_ACTIVE;
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge mem_clk) begin
		if (link_reset) begin
			state     <= ST_ACTIVE;
			state_cnt <= '0;
			cke_q     <= 1'b1;
		end else begin
			state     <= next_state;
			state_cnt <= next_state_cnt;
			cke_q     <= link_cmd.cke;
		end
	end

	// read window: off from edge RL-2 up to edge RL+BL/2
	assign next_rd_cnt = is_read ? count_of(1)
		: (rd_cnt != '0 && rd_cnt <= count_of(READ_END)) ? rd_cnt + 1'b1 : '0;

	always_ff @(posedge mem_clk) begin
		if (link_reset) begin
			rd_cnt   <= '0;
			read_off <= 1'b0;
		end else begin
			rd_cnt   <= next_rd_cnt;
			read_off <= next_rd_cnt >= count_of(READ_LATENCY - READ_OFF_LEAD_CYCLES + 1)
				&& next_rd_cnt <= count_of(READ_END);
		end
	end

	// zq calibration window
	always_ff @(posedge mem_clk) begin
		if (link_reset)
			zq_cnt <= '0;
		else if (cmd_valid && link_cmd.op == CMD_ZQ_CAL)
			zq_cnt <= count_of(ZQ_CAL_CYCLES);
		else if (zq_cnt != '0)
			zq_cnt <= zq_cnt - 1'b1;
	end

	// earliest CKE low after bursts
	always_comb begin
		next_cke_block_cnt = (cke_block_cnt != '0) ? cke_block_cnt - 1'b1 : cke_block_cnt;
		if (is_read)
			next_cke_block_cnt = max_gap(next_cke_block_cnt, count_of(READ_CKE_GAP));
		if (is_write)
			next_cke_block_cnt = max_gap(next_cke_block_cnt, count_of(WRITE_CKE_GAP));
		if (is_write_ap)
			next_cke_block_cnt = max_gap(next_cke_block_cnt, count_of(WRITE_CKE_GAP + 1));
	end

	always_ff @(posedge mem_clk) begin
		if (link_reset) begin
			cke_block_cnt <= '0;
			cke_level_cnt <= '0;
		end else begin
			cke_block_cnt <= next_cke_block_cnt;
			if (cke_fall || cke_rise)
				cke_level_cnt <= count_of(1);
			else if (cke_level_cnt != '1)
				cke_level_cnt <= cke_level_cnt + 1'b1;
		end
	end

	// far-side timing checks, sticky until link reset
	wire logic early_cke_low = cke_fall && cke_block_cnt > count_of(1);
	wire logic short_pulse   = (cke_fall || cke_rise) && cke_level_cnt != '0
		&& cke_level_cnt < count_of(CKE_MIN_PULSE);
	wire logic nop_missing   = state == ST_PD_WAIT && !link_cmd.cs_n;
	wire logic early_command = state == ST_PD_EXIT && !link_cmd.cs_n;

	always_ff @(posedge mem_clk) begin
		if (link_reset)
			link_violation <= 1'b0;
		else if (early_cke_low || short_pulse || nop_missing || early_command)
			link_violation <= 1'b1;
	end

	// power-down or self refresh gate for the core window timers
	always_ff @(posedge mem_clk) begin
		if (link_reset)
			lp_gate <= 1'b0;
		else
			lp_gate <= ((next_state == ST_PD_WAIT || next_state == ST_POWERDOWN) && !term_in_powerdown_bit)
				|| next_state == ST_SELFREF;
	end

	// select and state as one registered word for the core side
	always_ff @(posedge mem_clk) begin
		if (link_reset)
			link_status <= STATUS_RESET;
		else
			link_status <= {next_rtt, next_state};
	end

	// ---------------- core domain ----------------
	logic            gate_meta;
	logic            gate_sync;
	logic            gate_off;
	logic [CW-1:0]   win_cnt;
	logic            viol_meta;
	logic            viol_sync;
	logic [7:0]      status_meta;
	logic [7:0]      status_sync;
	logic [7:0]      status_prev;
	logic            rx_on;

	// receivers stay on outside the low-power states
	wire logic rx_seen = (status_sync[5:0] & (ST_ACTIVE | ST_PD_WAIT | ST_PD_EXIT)) != '0;

	wire logic [CW-1:0] win_target = gate_sync ? count_of(TERM_DISABLE_CYCLES) : count_of(TERM_ENABLE_CYCLES);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			gate_meta <= 1'b0;
			gate_sync <= 1'b0;
			viol_meta <= 1'b0;
			viol_sync <= 1'b0;
			status_meta <= STATUS_RESET;
			status_sync <= STATUS_RESET;
		end else if (enable) begin
			gate_meta <= lp_gate;
			gate_sync <= gate_meta;
			viol_meta <= link_violation;
			viol_sync <= viol_meta;
			status_meta <= link_status;
			status_sync <= status_meta;
		end
	end

	// window timer: follow the gate after the disable or enable count
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gate_off <= 1'b0;
			win_cnt  <= '0;
		end else if (enable) begin
			if (gate_sync == gate_off) begin
				win_cnt <= '0;
			end else if (win_cnt + 1'b1 >= win_target) begin
				gate_off <= gate_sync;
				win_cnt  <= '0;
			end else begin
				win_cnt <= win_cnt + 1'b1;
			end
		end
	end

	wire logic mode_on   = rtt_select_field != RTT_OFF;
	wire logic forced_off = ca_train || read_off || zq_cnt != '0 || state == ST_DEEP_PD || gate_off;

	assign term_out.dqs_term_en = on_die_termination_pin && mode_on && !forced_off;
	assign term_out.dq_term_en  = on_die_termination_pin && mode_on && !forced_off && !write_level;

	// status outputs, word taken only once two synced samples agree
	always_ff @(posedge core_clk) begin
		if (reset) begin
			status_prev            <= STATUS_RESET;
			termination_resistance <= RTT_OFF;
			pd_state               <= ST_ACTIVE;
			rx_on                  <= 1'b1;
		end else if (enable) begin
			status_prev <= status_sync;
			if (status_sync == status_prev) begin
				termination_resistance <= status_sync[7:6];
				pd_state               <= pd_state_e'(status_sync[5:0]);
				rx_on                  <= rx_seen;
			end
		end
	end

	// no refresh engine; in power-down the zq, read-window, CKE block and CKE level counters and the window timer keep running
	assign receivers_on       = rx_on;
	assign protocol_violation = viol_sync;

endmodule // term_pd_ctrl

/* File: test/term_pd_ctrl_properties.sv */
// port assertions for the termination and power-down controller
`timescale 1ns/1ps
module term_pd_checker
	import term_pd_pkg::*;
#(
	parameter int READ_LATENCY = READ_LATENCY_DEFAULT
) (
	// core domain
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       enable,
	// link domain
	input wire logic       mem_clk,
	input wire logic       link_reset,
	input wire link_cmd_s  link_cmd,
	input wire logic       on_die_termination_pin,
	// watched outputs
	input wire term_out_s  term_out,
	input wire logic [1:0] termination_resistance,
	input wire logic       receivers_on,
	input wire pd_state_e  pd_state,
	input wire logic       protocol_violation
);
	localparam int RD_OFF = READ_LATENCY - 1;
	wire rd_cmd = link_cmd.cke && !link_cmd.cs_n && (link_cmd.op inside {CMD_READ, CMD_READ_AP, CMD_MRR});

	chk_pin_low_off: assert property (@(posedge core_clk) disable iff (reset)
		!on_die_termination_pin |-> !term_out.dqs_term_en && !term_out.dq_term_en) else $error("termination on, pin low");
	chk_dq_needs_dqs: assert property (@(posedge core_clk) disable iff (reset)
		term_out.dq_term_en |-> term_out.dqs_term_en) else $error("data termination without strobe");
	chk_deep_pd_off: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pd_state == ST_DEEP_PD) |-> !term_out.dqs_term_en && !term_out.dq_term_en)
		else $error("termination on in deep power down");
	chk_recv_off_state: assert property (@(posedge core_clk) disable iff (reset)
		$fell(receivers_on) |-> pd_state inside {ST_POWERDOWN, ST_SELFREF, ST_DEEP_PD}) else $error("receivers off early");
	chk_violation_sticky: assert property (@(posedge core_clk) disable iff (reset)
		protocol_violation |=> protocol_violation) else $error("violation flag dropped");
	chk_pd_wait_len: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pd_state == ST_PD_WAIT) |-> (pd_state == ST_PD_WAIT) [*8] ##[1:4] pd_state == ST_POWERDOWN)
		else $error("wait before power-down wrong");
	chk_exit_latency: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pd_state == ST_PD_EXIT) |-> (pd_state == ST_PD_EXIT) [*8] ##[5:9] pd_state == ST_ACTIVE)
		else $error("exit latency wrong");
	chk_read_window: assert property (@(posedge mem_clk) disable iff (link_reset)
		rd_cmd && $past(link_cmd.cke) |-> ##RD_OFF (!term_out.dqs_term_en) [*6] ##1
		(!on_die_termination_pin || termination_resistance == RTT_OFF || term_out.dqs_term_en))
		else $error("read termination window wrong");
endmodule // term_pd_checker

bind term_pd_ctrl term_pd_checker #(.READ_LATENCY(READ_LATENCY)) u_chk (.core_clk(core_clk), .reset(reset),
	.enable(enable), .mem_clk(mem_clk), .link_reset(link_reset), .link_cmd(link_cmd),
	.on_die_termination_pin(on_die_termination_pin), .term_out(term_out),
	.termination_resistance(termination_resistance), .receivers_on(receivers_on), .pd_state(pd_state),
	.protocol_violation(protocol_violation));

/* File: test/mem_ctrl_model.sv */
// memory controller model: link clock, commands and termination pin
`timescale 1ns/1ps
module mem_ctrl_model
	import term_pd_pkg::*;
(
	// link side
	output logic      mem_clk,
	output logic      link_reset,
	output link_cmd_s link_cmd,
	output logic      on_die_termination_pin
);
	initial begin
		mem_clk = 1'h0;
		#7.3;
		forever #24 mem_clk = ~mem_clk;
	end
	initial begin
		link_reset = 1'h1;
		on_die_termination_pin = 1'h0;
		link_cmd = '{1'h1, 1'h1, CMD_NOP, 8'h00, 8'h00};
		repeat (3) @(posedge mem_clk);
		@(negedge mem_clk) link_reset = 1'h0;
	end
	// one command, taken at the next rising edge
	task automatic send(input logic cke, input logic cs_n, input cmd_e op, input logic [7:0] ma, input logic [7:0] d);
		@(negedge mem_clk);
		link_cmd = '{cke, cs_n, op, ma, d};
		@(posedge mem_clk);
	endtask
	// deselected edges, unused lines keep changing
	task automatic idle(input int n);
		repeat (n) send(link_cmd.cke, 1'h1, cmd_e'(4'($urandom_range(12))), 8'($urandom), 8'($urandom));
	endtask
	// entry command then six deselected edges, low past the minimum pulse
	task automatic power_down(input cmd_e op, input logic cs_n);
		send(1'h0, cs_n, op, 8'h00, 8'h00);
		idle(6);
	endtask
	// exit on a running clock, chip select high
	task automatic wake();
		send(1'h1, 1'h1, CMD_NOP, 8'h00, 8'h00);
		idle(8);
	endtask
endmodule // mem_ctrl_model

/* File: test/test_term_pd_ctrl.sv */
// self-checking bench for the termination and power-down controller
`timescale 1ns/1ps
module test_term_pd_ctrl
	import term_pd_pkg::*;
;
	logic       core_clk;
	logic       reset;
	logic       enable;
	wire        mem_clk, link_reset, pin;
	link_cmd_s  link_cmd;
	term_out_s  term_out;
	logic [1:0] termination_resistance;
	logic       receivers_on;
	pd_state_e  pd_state;
	logic       protocol_violation;
	int         error_cnt, comparisons, sel, wl, ca;
	localparam int RL = READ_LATENCY_DEFAULT;
	localparam int HB = BURST_LENGTH_DEFAULT / 2;
	logic [7:0] mode_ma[4] = '{MA_WRITE_LEVEL, MA_WRITE_LEVEL, MA_CA_TRAIN_ON, MA_CA_TRAIN_OFF};
	cmd_e       rd_op[3] = '{CMD_READ, CMD_READ_AP, CMD_MRR};
	cmd_e       pd_op[4] = '{CMD_NOP, CMD_NOP, CMD_SREF, CMD_DPD};
	pd_state_e  pd_st[4] = '{ST_POWERDOWN, ST_POWERDOWN, ST_SELFREF, ST_DEEP_PD};

	mem_ctrl_model ctrl (.mem_clk(mem_clk), .link_reset(link_reset), .link_cmd(link_cmd),
		.on_die_termination_pin(pin));
	term_pd_ctrl dut (.core_clk(core_clk), .reset(reset), .enable(enable), .mem_clk(mem_clk),
		.link_reset(link_reset), .link_cmd(link_cmd), .on_die_termination_pin(pin), .term_out(term_out),
		.termination_resistance(termination_resistance), .receivers_on(receivers_on), .pd_state(pd_state),
		.protocol_violation(protocol_violation));

	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// expected {data, strobe} termination
	function automatic logic [1:0] model(input logic off);
		logic on;
		on = pin && sel != 0 && ca == 0 && !off;
		return {on && wl == 0, on};
	endfunction
	task automatic mode_reg_write_cmd(input logic [7:0] ma, input logic [7:0] d);
		ctrl.send(1'h1, 1'h0, CMD_MRW, ma, d);
		ctrl.idle(1);
		#1;
	endtask
	task automatic wait_state(input pd_state_e st);
		for (int i = 0; i < 400 && pd_state !== st; i++) @(negedge core_clk);
		check("pd_state", pd_state, st);
		if (pd_state !== st) complete_run();
	endtask

	initial begin
		reset = 1'h1;
		enable = 1'h1;
		void'($urandom(32'hC89B1720));
		{sel, wl, ca} = 0;
		repeat (5) @(negedge core_clk);
		reset = 1'h0;
		@(negedge core_clk);
		check("resistance", termination_resistance, 8'h00);
		check("receivers", receivers_on, 8'h01);
		check("pd_state", pd_state, ST_ACTIVE);
		check("violation", protocol_violation, 8'h00);
		// link reset is released later by the controller model
		for (int i = 0; i < 40 && link_reset !== 1'h0; i++) @(negedge core_clk);
		check("link_reset", link_reset, 8'h00);
		if (link_reset !== 1'h0) complete_run();
		for (int s = 0; s < 4; s++) begin
			sel = s;
			mode_reg_write_cmd(MA_TERMINATION, 8'(s));
			for (int p = 0; p < 2; p++) begin
				ctrl.on_die_termination_pin = p[0];
				#1 check("term", term_out, model(0));
			end
			check("resistance", termination_resistance, 8'(s));
		end
		// enable low freezes the reported select
		@(negedge core_clk) enable = 1'h0;
		mode_reg_write_cmd(MA_TERMINATION, 8'h01);
		repeat (8) @(negedge core_clk);
		check("resistance", termination_resistance, 8'h03);
		enable = 1'h1;
		repeat (8) @(negedge core_clk);
		check("resistance", termination_resistance, 8'h01);
		mode_reg_write_cmd(MA_TERMINATION, 8'h03);
		foreach (mode_ma[i]) begin
			mode_reg_write_cmd(mode_ma[i], {i == 0, 7'h00});
			if (i < 2) wl = (i == 0);
			else ca = (i == 2);
			check("term", term_out, model(0));
		end
		ctrl.send(1'h1, 1'h0, CMD_ZQ_CAL, 8'h00, 8'h00);
		ctrl.idle(1);
		#1 check("term", term_out, model(1));
		ctrl.idle(70);
		foreach (rd_op[i]) begin
			ctrl.send(1'h1, 1'h0, rd_op[i], 8'($urandom), 8'h00);
			for (int k = 1; k <= RL + HB + 1; k++) begin
				ctrl.idle(1);
				#1 check("term", term_out, model(k >= RL - 2 && k < RL + HB));
			end
		end
		// bursts done before clock enable drops
		ctrl.idle(8);
		ctrl.send(1'h1, 1'h0, CMD_WRITE_AP, 8'h00, 8'h00);
		ctrl.idle(22);
		for (int i = 0; i < 4; i++) begin
			mode_reg_write_cmd(MA_TERMINATION, 8'(sel + 4 * (i == 1)));
			ctrl.power_down(pd_op[i], i < 2);
			wait_state(pd_st[i]);
			check("receivers", receivers_on, 8'h00);
			check("term", term_out, model(i != 1));
			ctrl.wake();
			wait_state(ST_ACTIVE);
			repeat (6) @(negedge core_clk);
			check("term", term_out, model(0));
			check("receivers", receivers_on, 8'h01);
		end
		check("violation", protocol_violation, 8'h00);
		ctrl.on_die_termination_pin = 1'h0;
		ctrl.send(1'h1, 1'h0, CMD_READ, 8'h00, 8'h00);
		ctrl.idle(4);
		ctrl.power_down(CMD_NOP, 1'h1);
		ctrl.wake();
		repeat (10) @(negedge core_clk);
		check("violation", protocol_violation, 8'h01);
		ctrl.link_reset = 1'h1;
		reset = 1'h1;
		ctrl.idle(3);
		@(negedge mem_clk) ctrl.link_reset = 1'h0;
		repeat (5) @(negedge core_clk);
		reset = 1'h0;
		@(negedge core_clk);
		check("violation", protocol_violation, 8'h00);
		complete_run();
	end
endmodule // test_term_pd_ctrl
